// ===== dv/line_partner.sv
// Far-end line model: signal level, descrambler lock, idle activity.
// Assumes the bench steers it with level commands synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module line_partner (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Bench commands
    input  wire logic sig_on,
    input  wire logic lock_on,
    input  wire logic act_on,
    // Line status toward the block
    output logic      signal_valid,
    output logic      descr_locked,
    output logic      lock_activity
);
    logic [1:0] phase_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) phase_r <= 2'h0;
        else phase_r <= phase_r + 2'h1;
    end
    // Lock cannot outlive the signal it was gained on
    assign signal_valid  = sig_on;
    assign descr_locked  = lock_on & sig_on;
    assign lock_activity = act_on & descr_locked & (phase_r == 2'h0);
endmodule
`default_nettype wire

// ===== dv/pcs_100m_config_status_tb.sv
// Self-checking bench for the coding sublayer config register and link.
// Assumes short timeout limits of 20 and 50 cycles in place of real ones.
`timescale 1ns/1ns
`default_nettype none
module pcs_100m_config_status_tb;
    logic                   clk_sys = 1'b0, rst_n = 1'b0;
    logic                   fiber_strap = 1'b0, reg_wr = 1'b0;
    logic [4:0]             reg_addr = 5'h00;
    logic [15:0]            reg_wdata = 16'h0000, reg_rdata;
    logic                   sig_on = 1'b0, lock_on = 1'b0, act_on = 1'b0;
    logic                   signal_valid, descr_locked, lock_activity;
    logic                   signal_detect, descr_timeout, link_up;
    pcs_cfg_pkg::path_ctl_t path_ctl;
    int                     fails = 0, checks_done = 0;
    localparam logic [4:0]  A = pcs_cfg_pkg::CFG_ADDR;
    always #10 clk_sys = ~clk_sys;
    pcs_100m_config_status #(.SHORT_CYC(20), .LONG_CYC(50)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .fiber_strap(fiber_strap),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .signal_valid(signal_valid),
        .descr_locked(descr_locked), .lock_activity(lock_activity),
        .path_ctl(path_ctl), .signal_detect(signal_detect),
        .descr_timeout(descr_timeout), .link_up(link_up));
    line_partner far_end (
        .clk_sys(clk_sys), .rst_n(rst_n), .sig_on(sig_on),
        .lock_on(lock_on), .act_on(act_on), .signal_valid(signal_valid),
        .descr_locked(descr_locked), .lock_activity(lock_activity));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        reg_addr = a;
        tick(1);
        chk(reg_rdata, exp);
    endtask
    task automatic do_reset(input logic strap);
        rst_n = 1'b0;
        fiber_strap = strap;
        tick(6);
        rst_n = 1'b1;
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
    initial begin
        do_reset(1'b0);
        rd(A, 16'h0100);
        do_reset(1'b1);
        rd(A, 16'h014b);
        chk({8'h00, path_ctl}, 16'h001b);
        wr(A, 16'hffff);
        rd(A, 16'h0fef);
        chk({8'h00, path_ctl}, 16'h00ff);
        wr(5'h15, 16'h0000);
        rd(5'h15, 16'h0000);
        rd(A, 16'h0fef);
        wr(A, 16'h0c04);
        chk({8'h00, path_ctl}, 16'h00c4);
        wr(A, 16'h0200);
        chk({15'h0, signal_detect}, 16'h0001);
        wr(A, 16'h0100);
        chk({15'h0, signal_detect}, 16'h0000);
        sig_on = 1'b1;
        lock_on = 1'b1;
        act_on = 1'b1;
        tick(3);
        chk({15'h0, link_up}, 16'h0001);
        lock_on = 1'b0;
        tick(3);
        chk({15'h0, link_up}, 16'h0001);
        wr(A, 16'h0000);
        tick(2);
        chk({15'h0, link_up}, 16'h0000);
        lock_on = 1'b1;
        tick(3);
        chk({15'h0, link_up}, 16'h0001);
        sig_on = 1'b0;
        tick(3);
        chk({15'h0, link_up}, 16'h0000);
        wr(A, 16'h0020);
        chk({15'h0, link_up}, 16'h0001);
        // Long limit first; reset then brings back the short limit and clears the flag
        sig_on = 1'b1;
        wr(A, 16'h0180);
        tick(4);
        act_on = 1'b0;
        tick(40);
        chk({15'h0, descr_timeout}, 16'h0000);
        tick(20);
        chk({15'h0, descr_timeout}, 16'h0001);
        act_on = 1'b1;
        do_reset(1'b0);
        tick(4);
        act_on = 1'b0;
        tick(15);
        chk({15'h0, descr_timeout}, 16'h0000);
        tick(10);
        chk({15'h0, descr_timeout}, 16'h0001);
        chk({15'h0, link_up}, 16'h0001);
        wr(A, 16'h0000);
        tick(2);
        chk({15'h0, link_up}, 16'h0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== logic/pcs_100m_config_status.sv
// Register and link qualification for the 100 Mb/s coding sublayer.
// Assumes register strobes, line status and strap are synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
// Function
// R1: Reserved bits ignore writes, read zero
// R2: Bit 11 selects free-running receive clock
// R3: Bit 10 enables true quiet transmit
// R4: Bit 9 forces signal detect
// R5: Bit 8 set: hold link on signal
// R6: Bit 8 clear: drop on lock loss
// R7: Bit 7 picks 2 ms timeout, else 722us
// R8: Bit 6 fiber enable, resets from strap
// R9: Bit 5 forces 100 Mb/s link good
// R10: Bit 3 far fault enable, strap reset
// R11: Bit 2 bypasses NRZI stage
// R12: Bit 1 scrambler skip, strap reset
// R13: Bit 0 descrambler skip, strap reset
module pcs_100m_config_status #(
    parameter int SHORT_CYC = pcs_cfg_pkg::SHORT_TMO_CYC,
    parameter int LONG_CYC  = pcs_cfg_pkg::LONG_TMO_CYC
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Strap
    input  wire logic              fiber_strap,
    // Register access
    input  wire logic [4:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [15:0]       reg_wdata,
    output logic      [15:0]       reg_rdata,
    // Line status
    input  wire logic              signal_valid,
    input  wire logic              descr_locked,
    input  wire logic              lock_activity,
    // Controls and status
    output pcs_cfg_pkg::path_ctl_t path_ctl,
    output logic                   signal_detect,
    output logic                   descr_timeout,
    output logic                   link_up
);
    logic [15:0] cfg_r, cfg_nxt;
    logic        link_r, link_nxt;
    logic [31:0] tmo_r, tmo_nxt;
    logic        tmo_flag_r, tmo_flag_nxt;
    logic [31:0] tmo_lim;
    logic        sd_int;

    // One address decode for the write and read paths
    function automatic logic cfg_hit(input logic [4:0] addr);
        cfg_hit = (addr == pcs_cfg_pkg::CFG_ADDR);
    endfunction

    // Reset value depends on strap, so it is loaded in a clocked way
    always_comb begin
        cfg_nxt = cfg_r;
        if (!rst_n) begin
            // R8: strap sets fiber default
            // R10: strap sets far fault default
            // R12: strap sets scrambler skip
            // R13: strap sets descrambler skip
            cfg_nxt = pcs_cfg_pkg::RESET_BASE |
                      (fiber_strap ? pcs_cfg_pkg::RESET_FIBER : 16'h0000);
        end else if (reg_wr && cfg_hit(reg_addr)) begin
            // R1: reserved bits masked off
            cfg_nxt = reg_wdata & pcs_cfg_pkg::WRITE_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        cfg_r <= cfg_nxt;
    end

    always_comb begin
        reg_rdata = 16'h0000;
        if (cfg_hit(reg_addr)) begin
            reg_rdata = cfg_r & pcs_cfg_pkg::WRITE_MASK;
        end
    end

    // R2: receive clock mode
    // R3: quiet transmit
    // R11: NRZI bypass
    always_comb begin
        path_ctl.rx_clk_free             = cfg_r[pcs_cfg_pkg::BIT_FREE_CLK];
        path_ctl.quiet_transmit_enable   = cfg_r[pcs_cfg_pkg::BIT_QUIET];
        path_ctl.force_signal_detect     = cfg_r[pcs_cfg_pkg::BIT_FORCE_SD];
        path_ctl.fiber_mode_enable       = cfg_r[pcs_cfg_pkg::BIT_FIBER];
        path_ctl.far_fault_report_enable = cfg_r[pcs_cfg_pkg::BIT_FAR_FAULT];
        path_ctl.nrzi_skip               = cfg_r[pcs_cfg_pkg::BIT_NRZI_SKIP];
        path_ctl.tx_scrambler_skip       = cfg_r[pcs_cfg_pkg::BIT_SCR_SKIP];
        path_ctl.rx_descrambler_skip     = cfg_r[pcs_cfg_pkg::BIT_DESCR_SKIP];
    end

    // R4: forced signal detect
    assign sd_int = signal_valid | cfg_r[pcs_cfg_pkg::BIT_FORCE_SD];
    assign signal_detect = sd_int;

    // R7: timeout length select
    assign tmo_lim = cfg_r[pcs_cfg_pkg::BIT_LONG_TMO] ? 32'(LONG_CYC) :
                                                        32'(SHORT_CYC);

    // Counter restarts on any lock activity; flag drops the link outside hold mode when it expires
    always_comb begin
        tmo_nxt = tmo_r;
        tmo_flag_nxt = tmo_flag_r;
        if (!rst_n || lock_activity || !descr_locked) begin
            tmo_nxt = 32'h0000_0000;
            tmo_flag_nxt = 1'b0;
        end else if (tmo_r >= tmo_lim - 32'h0000_0001) begin
            tmo_flag_nxt = 1'b1;
        end else begin
            tmo_nxt = tmo_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        tmo_r      <= tmo_nxt;
        tmo_flag_r <= tmo_flag_nxt;
    end
    assign descr_timeout = tmo_flag_r;

    always_comb begin
        link_nxt = link_r;
        if (!rst_n) begin
            link_nxt = 1'b0;
        end else if (!link_r) begin
            link_nxt = sd_int && descr_locked && !tmo_flag_r;
        end else if (!sd_int) begin
            link_nxt = 1'b0;
        end else if (!cfg_r[pcs_cfg_pkg::BIT_LINK_HOLD] &&
                     (!descr_locked || tmo_flag_r)) begin
            // R6: drop on lock loss
            link_nxt = 1'b0;
        end
        // R5: hold mode ignores lock loss above
    end

    always_ff @(posedge clk_sys) begin
        link_r <= link_nxt;
    end

    // R9: forced good link
    assign link_up = link_r | cfg_r[pcs_cfg_pkg::BIT_FORCE_OK];

    // Link qualification steps, used by the link rise and link wait properties
    sequence s_link_off;
        !link_r;
    endsequence

    sequence s_line_good;
        sd_int && descr_locked && !tmo_flag_r;
    endsequence

    a_reserved_zero: assert property ( // R1
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rdata & ~pcs_cfg_pkg::WRITE_MASK) == 16'h0000)
        else $error("reserved bits read nonzero");
    a_write_takes: assert property ( // R1
        @(posedge clk_sys) disable iff (!rst_n)
        reg_wr && cfg_hit(reg_addr) |=> cfg_r ==
        ($past(reg_wdata) & pcs_cfg_pkg::WRITE_MASK))
        else $error("config write lost");

    // Defaults are checked while reset is held, so no disable here
    a_strap_reset: assert property ( // R8
        @(posedge clk_sys)
        !rst_n |=> path_ctl.fiber_mode_enable == $past(fiber_strap) &&
        path_ctl.tx_scrambler_skip == $past(fiber_strap))
        else $error("strap default wrong");
    a_strap_far: assert property ( // R10
        @(posedge clk_sys)
        !rst_n |=> path_ctl.far_fault_report_enable == $past(fiber_strap) &&
        path_ctl.rx_descrambler_skip == $past(fiber_strap))
        else $error("strap far fault default wrong");
    a_reset_plain: assert property ( // R5
        @(posedge clk_sys)
        !rst_n |=> cfg_r[pcs_cfg_pkg::BIT_LINK_HOLD] &&
        !cfg_r[pcs_cfg_pkg::BIT_LONG_TMO] &&
        !cfg_r[pcs_cfg_pkg::BIT_FORCE_OK] &&
        !path_ctl.rx_clk_free && !path_ctl.quiet_transmit_enable &&
        !path_ctl.force_signal_detect && !path_ctl.nrzi_skip)
        else $error("plain reset default wrong");

    a_force_sd: assert property ( // R4
        @(posedge clk_sys) disable iff (!rst_n)
        path_ctl.force_signal_detect |-> signal_detect)
        else $error("signal detect not forced");
    a_sd_follow: assert property ( // R4
        @(posedge clk_sys) disable iff (!rst_n)
        !path_ctl.force_signal_detect |-> signal_detect == signal_valid)
        else $error("signal detect not following line");

    a_link_rise: assert property ( // R5
        @(posedge clk_sys) disable iff (!rst_n)
        s_link_off ##0 s_line_good |=> link_r)
        else $error("link failed to rise");
    a_link_wait: assert property ( // R6
        @(posedge clk_sys) disable iff (!rst_n)
        s_link_off ##0 !(sd_int && descr_locked) |=> !link_r)
        else $error("link rose without lock");
    a_hold_link: assert property ( // R5
        @(posedge clk_sys) disable iff (!rst_n)
        link_r && sd_int && cfg_r[pcs_cfg_pkg::BIT_LINK_HOLD] |=> link_r)
        else $error("link dropped in hold mode");
    a_drop_link: assert property ( // R6
        @(posedge clk_sys) disable iff (!rst_n)
        link_r && !descr_locked && !cfg_r[pcs_cfg_pkg::BIT_LINK_HOLD]
        |=> !link_r)
        else $error("link kept after lock loss");
    // Timeout counts as lock loss only outside hold mode
    a_tmo_drop: assert property ( // R6
        @(posedge clk_sys) disable iff (!rst_n)
        link_r && tmo_flag_r && !cfg_r[pcs_cfg_pkg::BIT_LINK_HOLD]
        |=> !link_r)
        else $error("link kept after timeout");
    a_no_sig_down: assert property ( // R5
        @(posedge clk_sys) disable iff (!rst_n)
        !sd_int |=> !link_r)
        else $error("link up without signal");

    a_tmo_clear: assert property ( // R7
        @(posedge clk_sys) disable iff (!rst_n)
        lock_activity || !descr_locked |=> !descr_timeout)
        else $error("timeout not cleared by activity");
    // Counter stalls one below the limit, so the long rise lands exactly there
    a_tmo_long: assert property ( // R7
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(descr_timeout) && $past(cfg_r[pcs_cfg_pkg::BIT_LONG_TMO])
        |-> $past(tmo_r) == 32'(LONG_CYC) - 32'h0000_0001)
        else $error("long timeout length wrong");
    // A switch from long to short may leave the count above the limit
    a_tmo_short: assert property ( // R7
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(descr_timeout) && !$past(cfg_r[pcs_cfg_pkg::BIT_LONG_TMO])
        |-> $past(tmo_r) >= 32'(SHORT_CYC) - 32'h0000_0001)
        else $error("short timeout too early");

    a_force_ok: assert property ( // R9
        @(posedge clk_sys) disable iff (!rst_n)
        cfg_r[pcs_cfg_pkg::BIT_FORCE_OK] |-> link_up)
        else $error("link not forced good");
    a_link_normal: assert property ( // R9
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_r[pcs_cfg_pkg::BIT_FORCE_OK] |-> link_up == link_r)
        else $error("link report not qualified");
endmodule
`default_nettype wire

// ===== pkg/pcs_cfg_pkg.sv
// Constants and carrier types for the 100 Mb/s coding sublayer config block.
// Assumes a management front end that supplies register address and strobes.
`default_nettype none
package pcs_cfg_pkg;
    localparam logic [4:0]  CFG_ADDR        = 5'h16;
    localparam int          BIT_FREE_CLK    = 11;
    localparam int          BIT_QUIET       = 10;
    localparam int          BIT_FORCE_SD    = 9;
    localparam int          BIT_LINK_HOLD   = 8;
    localparam int          BIT_LONG_TMO    = 7;
    localparam int          BIT_FIBER       = 6;
    localparam int          BIT_FORCE_OK    = 5;
    localparam int          BIT_FAR_FAULT   = 3;
    localparam int          BIT_NRZI_SKIP   = 2;
    localparam int          BIT_SCR_SKIP    = 1;
    localparam int          BIT_DESCR_SKIP  = 0;
    localparam logic [15:0] WRITE_MASK      = 16'h0fef;
    localparam logic [15:0] RESET_BASE      = 16'h0100;
    localparam logic [15:0] RESET_FIBER     = 16'h004b;
    localparam int          CLK_MHZ         = 50;
    localparam int          SHORT_TMO_US    = 722;
    localparam int          LONG_TMO_MS     = 2;
    localparam int          SHORT_TMO_CYC   = SHORT_TMO_US * CLK_MHZ;
    localparam int          LONG_TMO_CYC    = LONG_TMO_MS * 1000 * CLK_MHZ;

    typedef struct packed {
        logic rx_clk_free;
        logic quiet_transmit_enable;
        logic force_signal_detect;
        logic fiber_mode_enable;
        logic far_fault_report_enable;
        logic nrzi_skip;
        logic tx_scrambler_skip;
        logic rx_descrambler_skip;
    } path_ctl_t;
endpackage
`default_nettype wire
